/* File: vib_suppress_cfg.svh */
// Register offsets, field positions, reset values and timing figures of the vibration block.
`ifndef VIB_SUPPRESS_CFG_SVH
`define VIB_SUPPRESS_CFG_SVH

`define ADDR_W 12
`define OFS_TUNE_MODE 12'h000
`define OFS_C1_VIB_FREQ 12'h004
`define OFS_C1_RES_FREQ 12'h008
`define OFS_C1_VIB_DAMP 12'h00c
`define OFS_C1_RES_DAMP 12'h010
`define OFS_C2_VIB_FREQ 12'h014
`define OFS_C2_RES_FREQ 12'h018
`define OFS_C2_VIB_DAMP 12'h01c
`define OFS_C2_RES_DAMP 12'h020
`define OFS_LOOP_GAIN 12'h024
`define OFS_NOTCH 12'h028
`define OFS_STATUS 12'h02c

`define MODE_DIG_W 4
`define MODE_C1_LSB 0
`define MODE_C2_LSB 4
`define MODE_OFF 4'h0
`define MODE_AUTO 4'h1
`define MODE_MANUAL 4'h2

`define NOTCH_FREQ_LSB 0
`define NOTCH_DEPTH_LSB 8
`define NOTCH_CODE_OFF 8'h00
`define NOTCH_CODE_MAX 8'h5f

`define RST_FREQ 16'h03e8
`define RST_DAMP 16'h0000
`define RST_GAIN 16'h0018
`define RST_MODE 16'h0000
`define RST_NOTCH 12'h000

// Frequencies are in 0.1 Hz, loop gain in rad/s, two pi is scaled by 1000.
`define TWO_PI_K 48'd6283
`define C1_GAIN_K 48'd9000
`define C2_FLOOR 48'd50
`define RATIO_LO 48'd11
`define RATIO_HI 48'd55
`define RATIO_DEN 48'd10
`define C2_GAIN_K 48'd400000
`define C2_F1_K 48'd12
`define C2_F2_K 48'd5

`define TUNE_OPS 8'd10
`define SETTLE_MS 150
`define CLK_KHZ 125000

`endif

/* File: vib_suppress_pkg.sv */
// Types shared by the vibration suppression block.
package vib_suppress_pkg;

  typedef struct packed {
    logic enable;
    logic [7:0] freq_code;
    logic [3:0] depth_code;
    logic [9:0] depth_tenth_db;
  } notch_cfg_t;

  typedef struct packed {
    logic [15:0] vib_freq;
    logic [15:0] res_freq;
    logic [15:0] vib_damp;
    logic [15:0] res_damp;
  } ctrl_set_t;

  typedef enum logic [1:0] {
    NOTCH_IDLE = 2'b00,
    NOTCH_WAIT_STOP = 2'b01,
    NOTCH_SETTLE = 2'b11
  } notch_state_t;

endpackage

/* File: vibration_suppression_notch.sv */
// Vibration suppression controls and command notch configuration behind an APB slave.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`include "vib_suppress_cfg.svh"

// Contract
// RULE1: Auto mode loads estimates, two controls only.
// RULE2: After set positioning count, auto becomes manual.
// RULE3: Each control holds four separate manual settings.
// RULE4: Low digit control 1, next digit 2.
// RULE5: Writing 1 to digit two starts tuning.
// RULE6: Out-of-range frequency disables that control.
// RULE7: Control 1 frequencies exceed 0.9 gain/2pi.
// RULE8: Control 2 floor, ratio and gain limits.
// RULE9: Host keeps recommended margins on frequencies.
// RULE10: Notch frequency and depth are configurable.
// RULE11: Notch codes outside 4.5-2250 Hz disable.
// RULE12: New notch applied 150 ms after stop.
// RULE13: Both controls and notch run together.
// RULE14: Depth digit selects sixteen depths.
// RULE15: Code 00 disables, 01 is 2250 Hz.
// RULE16: Range checks rerun on gain or frequency write.
module vibration_suppression_notch
  import vib_suppress_pkg::*;
#(
  parameter int SETTLE_CYCLES = (`SETTLE_MS * `CLK_KHZ)
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic est_valid,
  input wire logic est_ctrl,
  input wire logic [15:0] est_vib_freq,
  input wire logic [15:0] est_res_freq,
  input wire logic positioning_done,
  input wire logic motor_moving,
  input wire logic servo_locked,
  output logic ctrl1_active,
  output logic ctrl2_active,
  output notch_cfg_t notch_cfg
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations and helpers.

  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [15:0] suppression_tuning_mode_select_ff;
  ctrl_set_t ctrl1_ff;
  ctrl_set_t ctrl2_ff;
  logic [15:0] model_loop_gain_ff;
  logic [11:0] position_notch_setting_ff;
  logic [7:0] c1_ops_ff;
  logic [7:0] c2_ops_ff;
  logic c1_usable_ff;
  logic c2_usable_ff;
  logic recheck_ff;
  logic ctrl1_active_ff;
  logic ctrl2_active_ff;
  notch_cfg_t notch_cfg_ff;
  notch_state_t notch_state_ff;
  notch_state_t nxt_notch_state;
  logic [31:0] settle_cnt_ff;
  logic notch_pending_ff;
  logic moving_s1_ff;
  logic moving_s2_ff;
  logic locked_s1_ff;
  logic locked_s2_ff;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [31:0] rd_val;
  logic [3:0] c1_mode;
  logic [3:0] c2_mode;
  logic settle_done;

  // Depth in tenths of a dB below unity for each depth digit.
  function automatic logic [9:0] depth_of(input logic [3:0] code);
    case (code)
      4'h0: depth_of = 10'd400;
      4'h1: depth_of = 10'd241;
      4'h2: depth_of = 10'd181;
      4'h3: depth_of = 10'd145;
      4'h4: depth_of = 10'd120;
      4'h5: depth_of = 10'd101;
      4'h6: depth_of = 10'd85;
      4'h7: depth_of = 10'd72;
      4'h8: depth_of = 10'd60;
      4'h9: depth_of = 10'd50;
      4'ha: depth_of = 10'd41;
      4'hb: depth_of = 10'd33;
      4'hc: depth_of = 10'd25;
      4'hd: depth_of = 10'd18;
      4'he: depth_of = 10'd12;
      default: depth_of = 10'd6;
    endcase
  endfunction

  // One register decode shared by the read and the write paths.
  function automatic logic is_mapped(input logic [`ADDR_W-1:0] a);
    is_mapped = (a <= `OFS_STATUS) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic freq_write(input logic [`ADDR_W-1:0] a);
    freq_write = (a == `OFS_C1_VIB_FREQ) || (a == `OFS_C1_RES_FREQ) ||
                 (a == `OFS_C2_VIB_FREQ) || (a == `OFS_C2_RES_FREQ) ||
                 (a == `OFS_LOOP_GAIN);
  endfunction

  assign hit = is_mapped(paddr);
  assign wr_en = psel && penable && pready_ff && pwrite && hit;
  assign rd_en = psel && penable && !pready_ff && !pwrite;
  assign c1_mode = suppression_tuning_mode_select_ff[`MODE_C1_LSB +: `MODE_DIG_W];
  assign c2_mode = suppression_tuning_mode_select_ff[`MODE_C2_LSB +: `MODE_DIG_W];

  ////////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, read data latched in the first access cycle, write data taken in the cycle with pready.

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !hit;
      if (rd_en) begin
        prdata_ff <= hit ? rd_val : 32'h0000_0000;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      `OFS_TUNE_MODE: rd_val = {16'h0000, suppression_tuning_mode_select_ff};
      `OFS_C1_VIB_FREQ: rd_val = {16'h0000, ctrl1_ff.vib_freq};
      `OFS_C1_RES_FREQ: rd_val = {16'h0000, ctrl1_ff.res_freq};
      `OFS_C1_VIB_DAMP: rd_val = {16'h0000, ctrl1_ff.vib_damp};
      `OFS_C1_RES_DAMP: rd_val = {16'h0000, ctrl1_ff.res_damp};
      `OFS_C2_VIB_FREQ: rd_val = {16'h0000, ctrl2_ff.vib_freq};
      `OFS_C2_RES_FREQ: rd_val = {16'h0000, ctrl2_ff.res_freq};
      `OFS_C2_VIB_DAMP: rd_val = {16'h0000, ctrl2_ff.vib_damp};
      `OFS_C2_RES_DAMP: rd_val = {16'h0000, ctrl2_ff.res_damp};
      `OFS_LOOP_GAIN: rd_val = {16'h0000, model_loop_gain_ff};
      `OFS_NOTCH: rd_val = {20'h00000, position_notch_setting_ff};
      `OFS_STATUS: rd_val = {c2_ops_ff, c1_ops_ff, 8'h00, notch_state_ff,
                             notch_pending_ff, notch_cfg_ff.enable,
                             c2_usable_ff, c1_usable_ff,
                             ctrl2_active_ff, ctrl1_active_ff};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Tuning mode select and positioning counts.

  // A software write wins over the automatic hand-over, so software may restart tuning.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      suppression_tuning_mode_select_ff <= `RST_MODE;
      c1_ops_ff <= 8'h00;
      c2_ops_ff <= 8'h00;
    end else if (wr_en && paddr == `OFS_TUNE_MODE) begin
      suppression_tuning_mode_select_ff <= pwdata[15:0]; // [RULE4]
      c1_ops_ff <= 8'h00;
      c2_ops_ff <= 8'h00; // [RULE5]
    end else begin
      if (c1_mode == `MODE_AUTO && positioning_done) begin
        if (c1_ops_ff + 8'h01 >= `TUNE_OPS) begin
          suppression_tuning_mode_select_ff[`MODE_C1_LSB +: `MODE_DIG_W] <= `MODE_MANUAL; // [RULE2]
        end
        c1_ops_ff <= c1_ops_ff + 8'h01;
      end
      if (c2_mode == `MODE_AUTO && positioning_done) begin
        if (c2_ops_ff + 8'h01 >= `TUNE_OPS) begin
          suppression_tuning_mode_select_ff[`MODE_C2_LSB +: `MODE_DIG_W] <= `MODE_MANUAL; // [RULE2]
        end
        c2_ops_ff <= c2_ops_ff + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter sets: software writes, or estimates while a control is tuning.

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_ff <= '{`RST_FREQ, `RST_FREQ, `RST_DAMP, `RST_DAMP};
    end else if (wr_en && paddr == `OFS_C1_VIB_FREQ) begin
      ctrl1_ff.vib_freq <= pwdata[15:0]; // [RULE3]
    end else if (wr_en && paddr == `OFS_C1_RES_FREQ) begin
      ctrl1_ff.res_freq <= pwdata[15:0];
    end else if (wr_en && paddr == `OFS_C1_VIB_DAMP) begin
      ctrl1_ff.vib_damp <= pwdata[15:0];
    end else if (wr_en && paddr == `OFS_C1_RES_DAMP) begin
      ctrl1_ff.res_damp <= pwdata[15:0];
    end else if (est_valid && !est_ctrl && c1_mode == `MODE_AUTO) begin
      ctrl1_ff.vib_freq <= est_vib_freq; // [RULE1]
      ctrl1_ff.res_freq <= est_res_freq;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl2_ff <= '{`RST_FREQ, `RST_FREQ, `RST_DAMP, `RST_DAMP};
    end else if (wr_en && paddr == `OFS_C2_VIB_FREQ) begin
      ctrl2_ff.vib_freq <= pwdata[15:0]; // [RULE3]
    end else if (wr_en && paddr == `OFS_C2_RES_FREQ) begin
      ctrl2_ff.res_freq <= pwdata[15:0];
    end else if (wr_en && paddr == `OFS_C2_VIB_DAMP) begin
      ctrl2_ff.vib_damp <= pwdata[15:0];
    end else if (wr_en && paddr == `OFS_C2_RES_DAMP) begin
      ctrl2_ff.res_damp <= pwdata[15:0];
    end else if (est_valid && est_ctrl && c2_mode == `MODE_AUTO) begin
      ctrl2_ff.vib_freq <= est_vib_freq; // [RULE1]
      ctrl2_ff.res_freq <= est_res_freq;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      model_loop_gain_ff <= `RST_GAIN;
      position_notch_setting_ff <= `RST_NOTCH;
    end else begin
      if (wr_en && paddr == `OFS_LOOP_GAIN) begin
        model_loop_gain_ff <= pwdata[15:0];
      end
      if (wr_en && paddr == `OFS_NOTCH) begin
        position_notch_setting_ff <= pwdata[11:0]; // [RULE10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Usable range checks, rerun one cycle after any relevant change.

  // Estimates change frequencies too, so they also request a recheck.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      recheck_ff <= 1'b1;
    end else begin
      recheck_ff <= (wr_en && freq_write(paddr)) || est_valid; // [RULE16]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      c1_usable_ff <= 1'b0;
      c2_usable_ff <= 1'b0;
    end else if (recheck_ff) begin
      c1_usable_ff <=
        ({32'h0, ctrl1_ff.vib_freq} * `TWO_PI_K > {32'h0, model_loop_gain_ff} * `C1_GAIN_K) &&
        ({32'h0, ctrl1_ff.res_freq} * `TWO_PI_K > {32'h0, model_loop_gain_ff} * `C1_GAIN_K); // [RULE7]
      c2_usable_ff <= (ctrl1_ff.vib_freq < ctrl2_ff.vib_freq) &&
        ({32'h0, ctrl2_ff.vib_freq} > `C2_FLOOR + {32'h0, model_loop_gain_ff}) &&
        ({32'h0, ctrl2_ff.res_freq} > `C2_FLOOR + {32'h0, model_loop_gain_ff}) &&
        ({32'h0, ctrl1_ff.vib_freq} * `RATIO_LO < {32'h0, ctrl2_ff.vib_freq} * `RATIO_DEN) &&
        ({32'h0, ctrl2_ff.vib_freq} * `RATIO_DEN < {32'h0, ctrl1_ff.vib_freq} * `RATIO_HI) &&
        ({32'h0, model_loop_gain_ff} * `C2_GAIN_K < `TWO_PI_K *
          ({32'h0, ctrl1_ff.vib_freq} * `C2_F1_K + {32'h0, ctrl2_ff.vib_freq} * `C2_F2_K)); // [RULE8]
    end
  end

  // The two controls run independently of the notch; the range check of control 2 uses the frequency of control 1.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_active_ff <= 1'b0;
      ctrl2_active_ff <= 1'b0;
    end else begin
      ctrl1_active_ff <= (c1_mode != `MODE_OFF) && c1_usable_ff && !recheck_ff; // [RULE6]
      ctrl2_active_ff <= (c2_mode != `MODE_OFF) && c2_usable_ff && !recheck_ff; // [RULE13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Notch apply sequencer.

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      moving_s1_ff <= 1'b0;
      moving_s2_ff <= 1'b0;
      locked_s1_ff <= 1'b0;
      locked_s2_ff <= 1'b0;
    end else begin
      moving_s1_ff <= motor_moving;
      moving_s2_ff <= moving_s1_ff;
      locked_s1_ff <= servo_locked;
      locked_s2_ff <= locked_s1_ff;
    end
  end

  assign settle_done = settle_cnt_ff >= SETTLE_CYCLES - 1;

  always_comb begin
    nxt_notch_state = notch_state_ff;
    case (notch_state_ff)
      NOTCH_IDLE: begin
        if (notch_pending_ff) begin
          nxt_notch_state = NOTCH_WAIT_STOP;
        end
      end
      NOTCH_WAIT_STOP: begin
        if (!moving_s2_ff && locked_s2_ff) begin
          nxt_notch_state = NOTCH_SETTLE;
        end
      end
      NOTCH_SETTLE: begin
        if (moving_s2_ff || !locked_s2_ff) begin
          nxt_notch_state = NOTCH_WAIT_STOP;
        end else if (settle_done) begin
          nxt_notch_state = NOTCH_IDLE;
        end
      end
      default: nxt_notch_state = NOTCH_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      notch_state_ff <= NOTCH_IDLE;
      settle_cnt_ff <= 32'h0000_0000;
    end else begin
      notch_state_ff <= nxt_notch_state;
      if (notch_state_ff == NOTCH_SETTLE && nxt_notch_state == NOTCH_SETTLE) begin
        settle_cnt_ff <= settle_cnt_ff + 32'h0000_0001; // [RULE12]
      end else begin
        settle_cnt_ff <= 32'h0000_0000;
      end
    end
  end

  // A write during settling restarts the wait only in its last cycle; the setting register is read when the wait ends, so the newest setting is applied.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      notch_pending_ff <= 1'b0;
      notch_cfg_ff <= '0;
    end else if (wr_en && paddr == `OFS_NOTCH) begin
      notch_pending_ff <= 1'b1;
    end else if (notch_state_ff == NOTCH_SETTLE && settle_done &&
                 !moving_s2_ff && locked_s2_ff) begin
      notch_pending_ff <= 1'b0;
      notch_cfg_ff.freq_code <= position_notch_setting_ff[`NOTCH_FREQ_LSB +: 8];
      notch_cfg_ff.depth_code <= position_notch_setting_ff[`NOTCH_DEPTH_LSB +: 4];
      notch_cfg_ff.depth_tenth_db <=
        depth_of(position_notch_setting_ff[`NOTCH_DEPTH_LSB +: 4]); // [RULE14]
      notch_cfg_ff.enable <=
        (position_notch_setting_ff[`NOTCH_FREQ_LSB +: 8] != `NOTCH_CODE_OFF) && // [RULE15]
        (position_notch_setting_ff[`NOTCH_FREQ_LSB +: 8] <= `NOTCH_CODE_MAX); // [RULE11]
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign ctrl1_active = ctrl1_active_ff;
  assign ctrl2_active = ctrl2_active_ff;
  assign notch_cfg = notch_cfg_ff;

endmodule

/* File: vsn_chk.sv */
// Concurrent checks on the ports of the vibration suppression block.
`timescale 1ns/10ps
`include "vib_suppress_cfg.svh"
module vsn_chk
  import vib_suppress_pkg::*;
#(
  parameter int SETTLE_CYCLES = (`SETTLE_MS * `CLK_KHZ)
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic est_valid,
  input wire logic est_ctrl,
  input wire logic [15:0] est_vib_freq,
  input wire logic [15:0] est_res_freq,
  input wire logic positioning_done,
  input wire logic motor_moving,
  input wire logic servo_locked,
  input wire logic ctrl1_active,
  input wire logic ctrl2_active,
  input wire notch_cfg_t notch_cfg
);
  logic [31:0] stop_cnt_ff;
  logic [2:0] quiet_ff;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  // Raw pin counts run ahead of the synced copy, so they bound the settle time from above.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) stop_cnt_ff <= '0;
    else if (motor_moving || !servo_locked) stop_cnt_ff <= '0;
    else if (stop_cnt_ff != '1) stop_cnt_ff <= stop_cnt_ff + 32'h1;
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) quiet_ff <= '0;
    else if ((pready && pwrite) || est_valid) quiet_ff <= '0;
    else if (quiet_ff != 3'h7) quiet_ff <= quiet_ff + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("pready high for more than one cycle");
  property p_rdy_cause;
    $rose(pready) |-> $past(psel && penable) && psel && penable;
  endproperty
  a_rdy_cause: assert property (p_rdy_cause)
    else $error("pready without an access phase");
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy)
    else $error("pslverr outside pready");
  property p_err_map;
    pready && (paddr > `OFS_STATUS || paddr[1:0] != 2'b00) |-> pslverr;
  endproperty
  a_err_map: assert property (p_err_map)
    else $error("unmapped access not refused");
  property p_err_zero;
    pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("refused read returns data");
  property p_notch_code;
    notch_cfg.enable |-> notch_cfg.freq_code != `NOTCH_CODE_OFF &&
      notch_cfg.freq_code <= `NOTCH_CODE_MAX;
  endproperty
  a_notch_code: assert property (p_notch_code)
    else $error("notch enabled with a code out of range");
  property p_depth;
    notch_cfg.enable |-> (notch_cfg.depth_code != 4'h0 || notch_cfg.depth_tenth_db == 10'd400)
      && (notch_cfg.depth_code != 4'hf || notch_cfg.depth_tenth_db == 10'd6);
  endproperty
  a_depth: assert property (p_depth)
    else $error("notch depth end points wrong");
  property p_settle;
    $changed(notch_cfg) |-> stop_cnt_ff >= SETTLE_CYCLES;
  endproperty
  a_settle: assert property (p_settle)
    else $error("notch applied before the motor settled");
  property p_act_cause;
    $changed(ctrl1_active) || $changed(ctrl2_active) |-> quiet_ff <= 3'h4;
  endproperty
  a_act_cause: assert property (p_act_cause)
    else $error("active output moved without a setting change");
  c_write: cover property (pready && pwrite && !pslverr);
  c_notch: cover property ($rose(notch_cfg.enable));
  c_both: cover property (ctrl1_active && ctrl2_active);
endmodule

bind vibration_suppression_notch vsn_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .est_valid(est_valid), .est_ctrl(est_ctrl), .est_vib_freq(est_vib_freq),
  .est_res_freq(est_res_freq), .positioning_done(positioning_done),
  .motor_moving(motor_moving), .servo_locked(servo_locked), .ctrl1_active(ctrl1_active),
  .ctrl2_active(ctrl2_active), .notch_cfg(notch_cfg));

/* File: motion_model.sv */
// Model of the command source, estimator and motor beside the vibration block.
`timescale 1ns/10ps
module motion_model (
  input wire logic mclk,
  output logic est_valid,
  output logic est_ctrl,
  output logic [15:0] est_vib_freq,
  output logic [15:0] est_res_freq,
  output logic positioning_done,
  output logic motor_moving,
  output logic servo_locked
);
  initial begin
    est_valid = 1'b0;
    est_ctrl = 1'b0;
    est_vib_freq = 16'h0;
    est_res_freq = 16'h0;
    positioning_done = 1'b0;
    motor_moving = 1'b0;
    servo_locked = 1'b1;
  end
  // Estimate lines are inverted once invalid so that stale data cannot pass as fresh.
  task automatic estimate(input logic c, input logic [15:0] v, input logic [15:0] r);
    @(posedge mclk);
    est_valid <= 1'b1;
    est_ctrl <= c;
    est_vib_freq <= v;
    est_res_freq <= r;
    @(posedge mclk);
    est_valid <= 1'b0;
    est_vib_freq <= ~v;
    est_res_freq <= ~r;
  endtask
  task automatic hold(input logic mv);
    @(posedge mclk);
    motor_moving <= mv;
    servo_locked <= !mv;
  endtask
  task automatic move(input int n);
    hold(1'b1);
    repeat (n) @(posedge mclk);
    motor_moving <= 1'b0;
    servo_locked <= 1'b1;
    positioning_done <= 1'b1;
    @(posedge mclk);
    positioning_done <= 1'b0;
  endtask
endmodule

/* File: vibration_suppression_notch_test.sv */
// Self-checking testbench of the vibration suppression block.
`timescale 1ns/10ps
`include "vib_suppress_cfg.svh"
module vibration_suppression_notch_test;
  import vib_suppress_pkg::*;
  localparam int SC = 20;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, est_valid, est_ctrl, positioning_done, motor_moving, servo_locked;
  logic [15:0] est_vib_freq, est_res_freq;
  logic ctrl1_active, ctrl2_active;
  notch_cfg_t notch_cfg;
  int n_mismatch = 0;
  int n_compared = 0;
  motion_model m (.mclk(mclk), .est_valid(est_valid), .est_ctrl(est_ctrl),
    .est_vib_freq(est_vib_freq), .est_res_freq(est_res_freq),
    .positioning_done(positioning_done), .motor_moving(motor_moving),
    .servo_locked(servo_locked));
  vibration_suppression_notch #(.SETTLE_CYCLES(SC)) dut (.mclk(mclk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .est_valid(est_valid),
    .est_ctrl(est_ctrl), .est_vib_freq(est_vib_freq), .est_res_freq(est_res_freq),
    .positioning_done(positioning_done), .motor_moving(motor_moving),
    .servo_locked(servo_locked), .ctrl1_active(ctrl1_active),
    .ctrl2_active(ctrl2_active), .notch_cfg(notch_cfg));
  initial begin
    forever #4 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Right after a rising edge the bench still sees the values sampled at that edge,
  // so pready, read data and pslverr are all taken at the edge that ends the access.
  task automatic apb(input logic w, input logic [`ADDR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) cmp(32'h0, 32'h1, "no pready");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [`ADDR_W-1:0] a, input logic [31:0] x, input logic xe,
      input string s);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    cmp(q, x, s);
    cmp({31'h0, e}, {31'h0, xe}, s);
  endtask
  task automatic act(input logic [1:0] x);
    repeat (4) @(negedge mclk);
    cmp({30'h0, ctrl2_active, ctrl1_active}, {30'h0, x}, "active");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] x;
    for (int i = 0; i < 11; i++) begin
      x = (i inside {1, 2, 5, 6}) ? 32'h3e8 : (i == 9) ? 32'h18 : 32'h0;
      rd(12'(i * 4), x, 1'b0, "reset value");
    end
    rd(12'h030, 32'h0, 1'b1, "unmapped");
    wr(12'h001, 32'h22);
    rd(`OFS_TUNE_MODE, 32'h0, 1'b0, "misaligned write");
    act(2'b00);
    rd(`OFS_STATUS, 32'h0000_0004, 1'b0, "status after reset");
  endtask
  task automatic t_rw;
    for (int i = 1; i < 9; i++) wr(12'(i * 4), 32'h100 + i);
    for (int i = 1; i < 9; i++) rd(12'(i * 4), 32'h100 + i, 1'b0, "set readback");
  endtask
  task automatic t_manual;
    wr(`OFS_LOOP_GAIN, 32'd24);
    wr(`OFS_C1_VIB_FREQ, 32'd100);
    wr(`OFS_C1_RES_FREQ, 32'd120);
    wr(`OFS_C2_VIB_FREQ, 32'd300);
    wr(`OFS_C2_RES_FREQ, 32'd320);
    wr(`OFS_TUNE_MODE, 32'h22);
    act(2'b11);
    wr(`OFS_TUNE_MODE, 32'h20);
    act(2'b10);
    wr(`OFS_TUNE_MODE, 32'h22);
    wr(`OFS_C1_VIB_FREQ, 32'd30);
    act(2'b00);
    wr(`OFS_C1_VIB_FREQ, 32'd100);
    act(2'b11);
    wr(`OFS_LOOP_GAIN, 32'd69);
    act(2'b01);
    wr(`OFS_LOOP_GAIN, 32'd70);
    act(2'b00);
    wr(`OFS_LOOP_GAIN, 32'd24);
    wr(`OFS_C2_VIB_FREQ, 32'd110);
    act(2'b01);
    wr(`OFS_C2_VIB_FREQ, 32'd111);
    act(2'b11);
    wr(`OFS_C2_RES_FREQ, 32'd74);
    act(2'b01);
    wr(`OFS_C2_RES_FREQ, 32'd75);
    act(2'b11);
  endtask
  task automatic t_tune;
    wr(`OFS_TUNE_MODE, 32'h10);
    m.estimate(1'b1, 16'd400, 16'd420);
    m.estimate(1'b0, 16'd150, 16'd160);
    rd(`OFS_C2_VIB_FREQ, 32'd400, 1'b0, "c2 estimate");
    rd(`OFS_C1_VIB_FREQ, 32'd100, 1'b0, "c1 not tuning");
    wr(`OFS_TUNE_MODE, 32'h11);
    m.estimate(1'b0, 16'd150, 16'd160);
    rd(`OFS_C1_RES_FREQ, 32'd160, 1'b0, "c1 estimate");
    repeat (9) m.move(3);
    rd(`OFS_TUNE_MODE, 32'h11, 1'b0, "still tuning");
    m.move(3);
    rd(`OFS_TUNE_MODE, 32'h22, 1'b0, "to manual");
    rd(`OFS_C1_VIB_FREQ, 32'd150, 1'b0, "estimate kept");
    act(2'b11);
    rd(`OFS_STATUS, 32'h0a0a_000f, 1'b0, "status after tuning");
  endtask
  task automatic t_notch;
    int n;
    logic [7:0] code[3] = '{8'h5f, 8'h60, 8'h00};
    n = 0;
    m.hold(1'b1);
    wr(`OFS_NOTCH, 32'h0f01);
    repeat (SC + 10) @(negedge mclk);
    cmp({31'h0, notch_cfg.enable}, 32'h0, "notch while moving");
    m.hold(1'b0);
    while (notch_cfg.enable !== 1'b1 && n < SC + 20) begin
      @(negedge mclk);
      n++;
    end
    cmp({31'h0, n >= SC && n < SC + 10}, 32'h1, "settle time");
    cmp({9'h0, notch_cfg}, {9'h0, 1'b1, 8'h01, 4'hf, 10'd6}, "notch 01");
    for (int i = 0; i < 3; i++) begin
      wr(`OFS_NOTCH, {24'h0, code[i]});
      repeat (SC + 10) @(negedge mclk);
      if (i == 0) cmp({9'h0, notch_cfg}, {9'h0, 1'b1, code[i], 4'h0, 10'd400}, "low");
      else cmp({31'h0, notch_cfg.enable}, 32'h0, "notch off");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_rw();
    t_manual();
    t_tune();
    t_notch();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
